//--- msp_mode_strap_sleep.sv
//Contract
// - The half-duplex strap is captured once after power-up reset and held regardless of later pin changes.
// - With that strap high, the request-to-send output carries the flow-control or general-purpose level.
// - With that strap low, the request-to-send output carries the RS-485 transmit-direction signal.
// - The infrared strap is captured once after power-up reset and the serial-pin personality stays fixed.
// - With the infrared strap high, transmit and receive pins carry plain UART data.
// - With the infrared strap low, transmit carries encoder output and receive feeds the infrared decoder.
// - After reset the sleep pin is an input and is not driven until configured as an output.
// - An asserted sleep input forces sleep once the next byte has been sent or received.
// - Configured as an output, the sleep pin shows that the device is asleep.
// - The transmit pin rests high in reset and UART idle, while the infrared encoder idles low.
`timescale 1ns/10ps
`include "msp_regs.svh"
module msp_mode_strap_sleep
   import msp_pkg::*;
#(
   parameter int CAP_CNT_W = 2
)
(
   // clock and reset
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   // strap pins
   input  wire logic half_duplex_strap_n_in,
   input  wire logic infrared_strap_n_in,
   // uart core side
   input  wire logic core_tx_data_in,
   input  wire logic ir_tx_data_in,
   input  wire logic flow_rts_n_in,
   input  wire logic rs485_dir_in,
   output logic      uart_rx_data_out,
   output logic      ir_rx_data_out,
   // serial pins
   output logic      tx_pin_out,
   input  wire logic rx_pin_in,
   output logic      rts_n_out,
   // sleep control
   input  wire logic sleep_pin_output_cfg_in,
   input  wire logic sleep_cond_in,
   input  wire logic byte_done_in,
   input  wire logic wake_in,
   output logic      sleep_mode_out,
   // sleep/power-down pin
   input  wire logic sleep_powerdown_pin_in,
   output logic      sleep_powerdown_pin_out,
   output logic      sleep_powerdown_pin_oe_out,
   // captured modes
   output logic      straps_valid_out,
   output logic      half_duplex_mode_out,
   output logic      infrared_mode_out
);

   // synchronisers for pins; first stages feed only second stages
   logic       hd_s1_r;
   logic       hd_s2_r;
   logic       ir_s1_r;
   logic       ir_s2_r;
   logic       rx_s1_r;
   logic       rx_s2_r;
   logic       sl_s1_r;
   logic       sl_s2_r;
   logic [CAP_CNT_W-1:0] cap_cnt_r;
   logic       valid_r;
   logic       hd_mode_r;
   logic       ir_mode_r;
   logic       tx_r;
   logic       rts_n_r;
   logic       urx_r;
   logic       irx_r;
   logic       slp_out_r;
   logic       slp_oe_r;

   msp_sleep_if slp_if ();

   // straps are active low: a low level picks the alternate personality
   function automatic logic strap_selects(input logic level);
      strap_selects = ~level;
   endfunction

   // pin level for a given sleep state; power-down sense is active low
   function automatic logic sleep_pin_level(input logic asleep);
      sleep_pin_level = asleep ? `MSP_SLEEP_PIN_ASLEEP : ~`MSP_SLEEP_PIN_ASLEEP;
   endfunction

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         hd_s1_r <= 1'b1;
         hd_s2_r <= 1'b1;
         ir_s1_r <= 1'b1;
         ir_s2_r <= 1'b1;
         rx_s1_r <= 1'b1;
         rx_s2_r <= 1'b1;
         sl_s1_r <= 1'b0;
         sl_s2_r <= 1'b0;
      end else begin
         hd_s1_r <= half_duplex_strap_n_in;
         hd_s2_r <= hd_s1_r;
         ir_s1_r <= infrared_strap_n_in;
         ir_s2_r <= ir_s1_r;
         rx_s1_r <= rx_pin_in;
         rx_s2_r <= rx_s1_r;
         sl_s1_r <= sleep_powerdown_pin_in;
         sl_s2_r <= sl_s1_r;
      end
   end

   // strap capture: a single shot after release, so later pin wiggles are ignored
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cap_cnt_r <= '0;
         valid_r   <= 1'b0;
         hd_mode_r <= 1'b0;
         ir_mode_r <= 1'b0;
      end else if (!valid_r) begin
         cap_cnt_r <= cap_cnt_r + CAP_CNT_W'(1);
         if (cap_cnt_r == CAP_CNT_W'(`MSP_CAPTURE_DELAY)) begin
            valid_r   <= 1'b1;
            hd_mode_r <= strap_selects(hd_s2_r);
            ir_mode_r <= strap_selects(ir_s2_r);
         end
      end
   end

   // serial pin personality: transmit side
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tx_r <= `MSP_TX_IDLE_UART;
      end else if (!valid_r) begin
         // mode not known yet, so hold the uart idle level rather than guess
         tx_r <= `MSP_TX_IDLE_UART;
      end else if (ir_mode_r) begin
         // encoder output, which idles low by itself
         tx_r <= ir_tx_data_in;
      end else begin
         tx_r <= core_tx_data_in;
      end
   end

   // receive side: the unused output is parked at its own idle level
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         urx_r <= `MSP_RX_IDLE_UART;
         irx_r <= `MSP_RX_IDLE_IR;
      end else if (!valid_r) begin
         urx_r <= `MSP_RX_IDLE_UART;
         irx_r <= `MSP_RX_IDLE_IR;
      end else if (ir_mode_r) begin
         urx_r <= `MSP_RX_IDLE_UART;
         irx_r <= rx_s2_r;
      end else begin
         urx_r <= rx_s2_r;
         irx_r <= `MSP_RX_IDLE_IR;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rts_n_r <= `MSP_RTS_IDLE_N;
      end else if (!valid_r) begin
         rts_n_r <= `MSP_RTS_IDLE_N;
      end else if (hd_mode_r) begin
         rts_n_r <= rs485_dir_in;
      end else begin
         // flow control or gpo on rts
         rts_n_r <= flow_rts_n_in;
      end
   end

   // the pin is only heard while we are not driving it, to avoid reading our own output
   assign slp_if.force_req  = sl_s2_r & ~slp_oe_r;
   assign slp_if.byte_done  = byte_done_in;
   assign slp_if.sleep_cond = sleep_cond_in;
   assign slp_if.wake       = wake_in;

   msp_sleep_ctl u_sleep_ctl (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .slp      (slp_if.ctl)
   );

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         slp_oe_r <= 1'b0;
      end else begin
         slp_oe_r <= sleep_pin_output_cfg_in;
      end
   end

   // level tracks the state even while undriven, so enabling the pin shows the truth at once
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         slp_out_r <= ~`MSP_SLEEP_PIN_ASLEEP;
      end else begin
         slp_out_r <= sleep_pin_level(slp_if.asleep);
      end
   end

   assign tx_pin_out                 = tx_r;
   assign rts_n_out                  = rts_n_r;
   assign uart_rx_data_out           = urx_r;
   assign ir_rx_data_out             = irx_r;
   assign sleep_mode_out             = slp_if.asleep;
   assign sleep_powerdown_pin_out    = slp_out_r;
   assign sleep_powerdown_pin_oe_out = slp_oe_r;
   assign straps_valid_out           = valid_r;
   assign half_duplex_mode_out       = hd_mode_r;
   assign infrared_mode_out          = ir_mode_r;

endmodule

//--- msp_regs.svh
`ifndef MSP_REGS_SVH
`define MSP_REGS_SVH

// counter value at which the straps are captured, on the third clock after reset release; covers the two-stage synchroniser
`define MSP_CAPTURE_DELAY 2'h2
// serial pin levels
`define MSP_TX_IDLE_UART  1'b1
`define MSP_RX_IDLE_UART  1'b1
`define MSP_RX_IDLE_IR    1'b0
// request-to-send output rests deasserted (active low)
`define MSP_RTS_IDLE_N    1'b1
// sleep/power-down pin level while asleep (power-down sense is active low)
`define MSP_SLEEP_PIN_ASLEEP 1'b0

`endif

//--- msp_pkg.sv
package msp_pkg;
   typedef enum logic [1:0] {
      MSP_AWAKE,
      MSP_ARMED,
      MSP_ASLEEP
   } msp_sleep_state_t;
endpackage

//--- msp_sleep_if.sv
`timescale 1ns/10ps
interface msp_sleep_if;
   logic force_req;
   logic byte_done;
   logic sleep_cond;
   logic wake;
   logic asleep;

   modport ctl (
      input  force_req,
      input  byte_done,
      input  sleep_cond,
      input  wake,
      output asleep
   );

   modport top (
      output force_req,
      output byte_done,
      output sleep_cond,
      output wake,
      input  asleep
   );
endinterface

//--- msp_sleep_ctl.sv
`timescale 1ns/10ps
`include "msp_regs.svh"
module msp_sleep_ctl
   import msp_pkg::*;
(
   // clock and reset
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   // sleep signals
   msp_sleep_if.ctl  slp
);

   msp_sleep_state_t state_r;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_r <= MSP_AWAKE;
      end else begin
         case (state_r)
            MSP_AWAKE: begin
               if (slp.sleep_cond) begin
                  state_r <= MSP_ASLEEP;
               end else if (slp.force_req) begin
                  state_r <= MSP_ARMED;
               end
            end
            MSP_ARMED: begin
               if (slp.byte_done || slp.sleep_cond) begin
                  state_r <= MSP_ASLEEP;
               end else if (!slp.force_req) begin
                  state_r <= MSP_AWAKE;
               end
            end
            MSP_ASLEEP: begin
               if (slp.wake) begin
                  state_r <= MSP_AWAKE;
               end
            end
            default: begin
               state_r <= MSP_AWAKE;
            end
         endcase
      end
   end

   assign slp.asleep = (state_r == MSP_ASLEEP);

endmodule

//--- msp_far_model.sv
`timescale 1ns/10ps
module msp_far_model (
   // host and transceiver intent
   input  wire logic force_sleep_in,
   input  wire logic rx_bit_in,
   // device side of the pins
   input  wire logic dev_pin_in,
   input  wire logic dev_pin_oe_in,
   output logic      rx_line_out,
   output logic      sleep_line_out
);
   assign rx_line_out = rx_bit_in;
   // host forces sleep
   // host lets go of the line whenever the device drives it
   assign sleep_line_out = dev_pin_oe_in ? dev_pin_in : force_sleep_in;
endmodule

//--- msp_mode_strap_sleep_sva.sv
`timescale 1ns/10ps
module msp_mss_sva (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic core_tx_data_in,
   input wire logic rs485_dir_in,
   input wire logic sleep_pin_output_cfg_in,
   input wire logic sleep_cond_in,
   input wire logic wake_in,
   input wire logic tx_pin_out,
   input wire logic rts_n_out,
   input wire logic sleep_mode_out,
   input wire logic sleep_powerdown_pin_out,
   input wire logic sleep_powerdown_pin_oe_out,
   input wire logic straps_valid_out,
   input wire logic half_duplex_mode_out,
   input wire logic infrared_mode_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   a_modes_hold: assert property (straps_valid_out |=> straps_valid_out && $stable(half_duplex_mode_out)
      && $stable(infrared_mode_out)) else $error("captured modes changed");
   a_tx_uart: assert property (straps_valid_out && !infrared_mode_out |=>
      tx_pin_out == $past(core_tx_data_in)) else $error("tx pin not uart data");
   a_rts_dir: assert property (straps_valid_out && half_duplex_mode_out |=>
      rts_n_out == $past(rs485_dir_in)) else $error("rts not direction");
   a_oe_follows: assert property (1'b1 |=>
      sleep_powerdown_pin_oe_out == $past(sleep_pin_output_cfg_in)) else $error("sleep pin oe wrong");
   a_cond_sleeps: assert property (!sleep_mode_out && sleep_cond_in |=> sleep_mode_out)
      else $error("no sleep on condition");
   a_pin_shows: assert property (1'b1 |=>
      sleep_powerdown_pin_out == !$past(sleep_mode_out)) else $error("sleep pin level wrong");
   a_sleep_holds: assert property (sleep_mode_out && !wake_in |=> sleep_mode_out)
      else $error("sleep dropped early");
   a_wake_exit: assert property (sleep_mode_out && wake_in |=> !sleep_mode_out)
      else $error("no wake");
endmodule
bind msp_mode_strap_sleep msp_mss_sva chk_u (.*);

//--- msp_mode_strap_sleep_tb.sv
`timescale 1ns/10ps
module msp_mode_strap_sleep_tb;
   logic clk_in = 1'b0, rst_n_in = 1'b0, half_duplex_strap_n_in = 1'b1, infrared_strap_n_in = 1'b1;
   logic core_tx_data_in = 1'b1, ir_tx_data_in = 1'b0, flow_rts_n_in = 1'b1, rs485_dir_in = 1'b0;
   logic sleep_pin_output_cfg_in = 1'b0, sleep_cond_in = 1'b0, byte_done_in = 1'b0, wake_in = 1'b0;
   logic force_r = 1'b0, rx_bit_r = 1'b1;
   logic rx_pin_in, sleep_powerdown_pin_in, uart_rx_data_out, ir_rx_data_out, tx_pin_out, rts_n_out;
   logic sleep_mode_out, sleep_powerdown_pin_out, sleep_powerdown_pin_oe_out;
   logic straps_valid_out, half_duplex_mode_out, infrared_mode_out;
   int   fail_count = 0;
   int   n_tests = 0;
   msp_mode_strap_sleep dut_u (.*);
   msp_far_model far_u (.force_sleep_in(force_r), .rx_bit_in(rx_bit_r), .dev_pin_in(sleep_powerdown_pin_out),
      .dev_pin_oe_in(sleep_powerdown_pin_oe_out), .rx_line_out(rx_pin_in), .sleep_line_out(sleep_powerdown_pin_in));
   initial forever #5 clk_in = ~clk_in;
   task automatic chk(input string nm, input logic v, input logic e);
      n_tests++;
      if (v !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %b seen %b", nm, e, v);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // capture once, then route the tx, rx and rts pins by mode
   task automatic t_straps(input logic h, input logic i);
      @(posedge clk_in);
      rst_n_in <= 1'b0;
      half_duplex_strap_n_in <= h;
      infrared_strap_n_in <= i;
      repeat (16) @(posedge clk_in);
      #1 chk("tx_in_reset", tx_pin_out, 1'b1);
      @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      #1 chk("valid_early", straps_valid_out, 1'b0);
      @(posedge clk_in);
      #1 chk("valid", straps_valid_out, 1'b1);
      chk("oe_after_reset", sleep_powerdown_pin_oe_out, 1'b0);
      @(posedge clk_in);
      half_duplex_strap_n_in <= !h;
      infrared_strap_n_in <= !i;
      core_tx_data_in <= 1'b0;
      ir_tx_data_in <= 1'b1;
      flow_rts_n_in <= 1'b0;
      rs485_dir_in <= 1'b1;
      rx_bit_r <= !i;
      repeat (4) @(posedge clk_in);
      #1 chk("hd_mode", half_duplex_mode_out, !h);
      chk("ir_mode", infrared_mode_out, !i);
      chk("tx_pin", tx_pin_out, !i);
      chk("rts_pin", rts_n_out, !h);
      chk("uart_rx", uart_rx_data_out, !i);
      chk("ir_rx", ir_rx_data_out, !i);
   endtask
   task automatic t_sleep;
      @(posedge clk_in);
      sleep_pin_output_cfg_in <= 1'b1;
      sleep_cond_in <= 1'b1;
      @(posedge clk_in);
      sleep_cond_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      #1 chk("pin_oe", sleep_powerdown_pin_oe_out, 1'b1);
      chk("pin_asleep", sleep_powerdown_pin_out, 1'b0);
      repeat (5) @(posedge clk_in);
      #1 chk("still_asleep", sleep_mode_out, 1'b1);
      @(posedge clk_in);
      wake_in <= 1'b1;
      @(posedge clk_in);
      wake_in <= 1'b0;
      #1 chk("woken", sleep_mode_out, 1'b0);
      @(posedge clk_in);
      #1 chk("pin_awake", sleep_powerdown_pin_out, 1'b1);
   endtask
   // forced sleep waits for the next byte
   task automatic t_force;
      @(posedge clk_in);
      sleep_pin_output_cfg_in <= 1'b0;
      force_r <= 1'b1;
      repeat (6) @(posedge clk_in);
      #1 chk("no_byte_yet", sleep_mode_out, 1'b0);
      @(posedge clk_in);
      byte_done_in <= 1'b1;
      @(posedge clk_in);
      byte_done_in <= 1'b0;
      force_r <= 1'b0;
      #1 chk("forced_sleep", sleep_mode_out, 1'b1);
      @(posedge clk_in);
      wake_in <= 1'b1;
      @(posedge clk_in);
      wake_in <= 1'b0;
      #1 chk("forced_wake", sleep_mode_out, 1'b0);
   endtask
   initial begin
      for (int k = 0; k < 4; k++) begin
         t_straps(k[1], k[0]);
      end
      t_sleep();
      t_force();
      end_sim();
   end
   initial begin
      #20000;
      fail_count++;
      end_sim();
   end
endmodule
